/* File: dv/fbrv_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module fbrv_monitor (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Streams
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_data,
  input wire logic        rsp_last,
  input wire logic [7:0]  rsp_dst_ep,
  input wire logic        rsp_ready,
  // Flash and checker
  input wire logic        fl_req,
  input wire logic [15:0] fl_offset,
  input wire logic        fl_ack,
  input wire logic        fl_err,
  input wire logic        chk_start,
  input wire logic        chk_done,
  input wire logic        rx_blocked,
  input wire logic        install_reset
);
  logic acc_last;
  assign acc_last = rsp_valid && rsp_ready && rsp_last;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_one_at_time: assert property (rsp_valid |-> !req_ready)
    else $error("request accepted during a reply");
  chk_reply_hold: assert property (rsp_valid && !rsp_ready |=>
    rsp_valid && $stable(rsp_data) && $stable(rsp_last))
    else $error("stalled reply byte changed");
  chk_dest_hold: assert property (rsp_valid && !rsp_last |=>
    $stable(rsp_dst_ep)) else $error("reply endpoint moved");
  chk_read_first: assert property (fl_req |-> !rsp_valid)
    else $error("reply began before reads ended");
  chk_offset_step: assert property (fl_req && fl_ack && !fl_err |=>
    !fl_req || fl_offset == $past(fl_offset) + 16'h1)
    else $error("flash offset did not advance");
  chk_fail_stop: assert property (fl_ack && fl_err |=> !fl_req)
    else $error("reads went on after a failure");
  chk_gate_start: assert property (chk_start |-> rx_blocked)
    else $error("receive open while check starts");
  chk_gate_hold: assert property (rx_blocked && !chk_done &&
    !$past(chk_done) |=> rx_blocked) else $error("receive reopened early");
  chk_reset_after: assert property (install_reset |->
    !rsp_valid && ($past(acc_last) || $past(acc_last, 2)))
    else $error("install reset not after reply");
  chk_reset_pulse: assert property (install_reset |=> !install_reset)
    else $error("install reset longer than a cycle");
  cover property (install_reset);
  cover property (chk_done);
  cover property (fl_ack && fl_err);
endmodule
`default_nettype wire

/* File: dv/fbrv_partner.sv */
`timescale 1ns/1ns
`default_nettype none
module fbrv_partner (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Flash read port
  input wire logic        fl_req,
  input wire logic [15:0] fl_block,
  input wire logic [15:0] fl_offset,
  output logic            fl_ack,
  output logic [7:0]      fl_rdata,
  output logic            fl_err,
  // Image checker
  input wire logic        chk_start,
  output logic            chk_done,
  output logic [7:0]      chk_status,
  // Behaviour chosen by the bench
  input wire logic [1:0]  dly,
  input wire logic        err_en,
  input wire logic [7:0]  cst
);
  logic [1:0] fcnt;
  logic [3:0] ccnt;
  logic [7:0] pat;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      fcnt <= 2'h0;
    else if (!fl_req || fcnt == 2'h0)
      fcnt <= dly;
    else
      fcnt <= fcnt - 2'h1;
  assign fl_ack = fl_req && fcnt == 2'h0;
  assign pat = fl_offset[7:0] ^ {fl_block[3:0], 4'h5};
  // Between beats the lines show the inverse, never a stale byte
  assign fl_rdata = fl_ack ? pat : ~pat;
  assign fl_err = fl_ack && err_en;
  // Check time is shortened to a dozen cycles
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      ccnt <= 4'h0;
    else if (chk_start)
      ccnt <= 4'hc;
    else if (ccnt != 4'h0)
      ccnt <= ccnt - 4'h1;
  assign chk_done = ccnt == 4'h1;
  assign chk_status = chk_done ? cst : ~cst;
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, dly;
  logic [2:0]  hsize;
  logic        req_valid, req_last, req_ready, rsp_valid, rsp_last;
  logic [7:0]  req_data, req_src_ep, rsp_data, rsp_dst_ep, fl_rdata, cst;
  logic        fl_req, fl_ack, fl_err, mem_busy, chk_start, chk_done;
  logic        rx_blocked, install_reset, err_en, rsp_ready;
  logic [15:0] fl_block, fl_offset, n, s, b;
  logic [7:0]  chk_status, mp;
  logic [16:0] q[$];
  int          mismatches, total_checks, cyc, n_rep, n_inst;
  fbrv_top #(.NUM_BLOCKS(4), .BLOCK_BYTES(64), .MAX_READ(16)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .req_valid,
    .req_data, .req_last, .req_src_ep, .req_ready, .rsp_valid, .rsp_data,
    .rsp_last, .rsp_dst_ep, .rsp_ready, .fl_req, .fl_block, .fl_offset,
    .fl_ack, .fl_rdata, .fl_err, .mem_busy, .chk_start, .chk_done,
    .chk_status, .rx_blocked, .install_reset);
  fbrv_partner pm (.hclk, .hresetn, .fl_req, .fl_block, .fl_offset,
    .fl_ack, .fl_rdata, .fl_err, .chk_start, .chk_done, .chk_status,
    .dly, .err_en, .cst);
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] e, v, input string nm);
    total_checks++;
    if (e !== v)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
    rd = hrdata;
  endtask
  task automatic put(input logic [7:0] d, input logic l);
    req_valid <= 1'b1;
    req_data <= d;
    req_last <= l;
    do @(posedge hclk); while (!req_ready);
  endtask
  task automatic frame(input logic [7:0] c, input logic [15:0] bk, st, nb,
                       input logic x);
    logic [7:0]  sv, ep;
    logic [15:0] k, o;
    logic [63:0] h;
    ep = 8'($urandom);
    req_src_ep <= ep;
    h = {c, 8'h00, bk, st, nb};
    for (int i = 0; i < 8; i++)
      put(h[63-8*i -: 8], !x && i == 7);
    if (x)
      put(8'h5a, 1'b1);
    req_valid <= 1'b0;
    if (mem_busy)
      sv = 8'h07;
    else if (c == fbrv_pkg::CMD_FETCH)
      sv = x ? 8'h02 : bk >= 4 ? 8'h03 : st + nb > 64 ? 8'h04 :
           nb > 16 || nb + 16'h8 > {8'h0, mp} ? 8'h31 :
           err_en ? 8'h30 : 8'h00;
    else if (c == 8'h05 || c == 8'h06)
      sv = cst;
    else
      sv = 8'h06;
    k = (sv == 8'h00 && c == 8'h04) ? nb : 16'h0;
    h = {c | 8'h80, sv, bk, st, k};
    for (int i = 0; i < 8; i++)
      q.push_back({k == 0 && i == 7, ep, h[63-8*i -: 8]});
    for (int j = 0; j < k; j++)
    begin
      o = st + 16'(j);
      q.push_back({j == k - 1, ep, o[7:0] ^ {bk[3:0], 4'h5}});
    end
    n_rep++;
    // One idle edge, so req_valid is never lowered and raised at once
    @(posedge hclk);
  endtask
  task automatic drain;
    while (q.size() != 0)
      @(posedge hclk);
    repeat (4) @(posedge hclk);
  endtask
  always @(posedge hclk)
    if (hresetn && rsp_valid && rsp_ready)
      cmp({15'h0, q.size() ? q.pop_front() : 17'h1ffff},
          {15'h0, rsp_last, rsp_dst_ep, rsp_data}, "reply");
  always @(posedge hclk)
    rsp_ready <= $urandom % 4 != 0;
  always @(posedge hclk)
    if (install_reset === 1'b1)
      n_inst++;
  always @(posedge hclk)
    if (++cyc == 30000)
    begin
      mismatches++;
      close_out;
    end
  initial
  begin
    {hresetn, hsel, hwrite, req_valid, req_last, mem_busy, err_en} = '0;
    {haddr, hwdata, htrans, dly, req_data, req_src_ep, cst} = '0;
    hsize = 3'h2;
    mp = 8'h64;
    void'($urandom(32'hfe20));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h0, 32'h0);
    cmp(32'h1, rd, "ctrl");
    ahb(1'b0, 32'h4, 32'h0);
    cmp(32'h64, rd, "max payload");
    ahb(1'b1, 32'h20, 32'h0);
    ahb(1'b0, 32'h20, 32'h0);
    cmp(32'h0, rd, "unmapped");
    ahb(1'b0, 32'h0, 32'h0);
    cmp(32'h1, rd, "ctrl after unmapped write");
    $display("test registers done");
    repeat (6)
    begin
      dly <= 2'($urandom);
      n = 16'(1 + $urandom % 16);
      b = 16'($urandom % 4);
      s = 16'($urandom % (65 - n));
      frame(8'h04, b, s, n, 1'b0);
    end
    frame(8'h04, 16'h3, 16'h3f, 16'h1, 1'b0);
    frame(8'h04, 16'h0, 16'h3c, 16'h8, 1'b0);
    frame(8'h04, 16'h4, 16'h0, 16'h1, 1'b0);
    frame(8'h04, 16'h0, 16'h0, 16'h11, 1'b0);
    frame(8'h04, 16'h1, 16'h2, 16'h2, 1'b1);
    frame(8'h04, 16'h2, 16'h5, 16'h0, 1'b0);
    frame(8'h07, 16'h1, 16'h1, 16'h0, 1'b0);
    drain();
    err_en <= 1'b1;
    frame(8'h04, 16'h1, 16'h3, 16'h4, 1'b0);
    drain();
    err_en <= 1'b0;
    mem_busy <= 1'b1;
    frame(8'h04, 16'h0, 16'h0, 16'h1, 1'b0);
    drain();
    mem_busy <= 1'b0;
    ahb(1'b1, 32'h4, 32'hc);
    mp = 8'h0c;
    ahb(1'b0, 32'h4, 32'h0);
    cmp(32'hc, rd, "max payload written");
    frame(8'h04, 16'h1, 16'h0, 16'h5, 1'b0);
    drain();
    ahb(1'b1, 32'h4, 32'h64);
    mp = 8'h64;
    $display("test fetch done");
    for (int i = 0; i < 4; i++)
    begin
      cst <= 8'(32'h4241_4000 >> (8 * i));
      frame(8'h05, 16'h0, 16'h0, 16'h0, 1'b0);
      drain();
    end
    cst <= 8'h42;
    frame(8'h06, 16'h0, 16'h0, 16'h0, 1'b0);
    drain();
    cst <= 8'h00;
    frame(8'h06, 16'h0, 16'h0, 16'h0, 1'b0);
    drain();
    cmp(32'h1, 32'(n_inst), "install pulses");
    $display("test check done");
    ahb(1'b0, 32'hc, 32'h0);
    cmp(32'(n_rep), {16'h0, rd[15:0]}, "reply count");
    ahb(1'b0, 32'h8, 32'h0);
    cmp(32'h0, {24'h0, rd[7:0]}, "last status");
    close_out();
  end
endmodule
bind fbrv_top fbrv_monitor mon (.hclk, .hresetn, .req_ready, .rsp_valid,
  .rsp_data, .rsp_last, .rsp_dst_ep, .rsp_ready, .fl_req, .fl_offset,
  .fl_ack, .fl_err, .chk_start, .chk_done, .rx_blocked, .install_reset);
`default_nettype wire

/* File: logic/fbrv_pkg.sv */
// Function
// [RULE_01] Fetch requests carry command code 0x04
// [RULE_02] Fetch options field is sent as zero
// [RULE_03] Block picks block, start picks byte offset
// [RULE_04] Start plus count stays within one block
// [RULE_05] Whole frame fits the maximum payload size
// [RULE_06] Fetch request carries no data bytes
// [RULE_07] Fetch reply carries code 0x84
// [RULE_08] Reply goes to the requesting source endpoint
// [RULE_09] Status zero means success, nonzero error
// [RULE_10] Fetch reply echoes block and start
// [RULE_11] Fetch reply returns bytes and count
// [RULE_12] Check uses 0x05, check-and-install 0x06
// [RULE_13] Check commands examine the stored image
// [RULE_14] Valid install: reply first, then reset
// [RULE_15] Check commands use zero unused fields
// [RULE_16] Radio receive blocked while checking image
// [RULE_17] Check-only reply carries code 0x85
// [RULE_18] Status 0x04 boundary, 0x03 bad block
// [RULE_19] Status 0x31 too long, 0x30 read fail
// [RULE_20] Status 0x06 unknown, 0x07 busy
// [RULE_21] Check status 0x40, 0x41, 0x42
// [RULE_22] One command replied before next accepted
`default_nettype none
package fbrv_pkg;
  localparam logic [7:0] CMD_FETCH   = 8'h04;
  localparam logic [7:0] CMD_CHECK   = 8'h05;
  localparam logic [7:0] CMD_INSTALL = 8'h06;
  localparam logic [7:0] REPLY_BIT   = 8'h80;
  localparam logic [7:0] ST_OK       = 8'h00;
  localparam logic [7:0] ST_BAD_LEN  = 8'h02;
  localparam logic [7:0] ST_NO_BLOCK = 8'h03;
  localparam logic [7:0] ST_BOUNDARY = 8'h04;
  localparam logic [7:0] ST_UNKNOWN  = 8'h06;
  localparam logic [7:0] ST_BUSY     = 8'h07;
  localparam logic [7:0] ST_RD_FAIL  = 8'h30;
  localparam logic [7:0] ST_TOO_LONG = 8'h31;
  localparam logic [7:0] ST_CHK_FAIL = 8'h40;
  localparam logic [7:0] ST_CHK_INCOMPAT = 8'h41;
  localparam logic [7:0] ST_CHK_CORRUPT  = 8'h42;
  // Request and reply header: cmd, opt/status, block, start, count
  localparam logic [3:0] HDR_LEN     = 4'h8;
  localparam logic [3:0] HDR_OVER    = 4'h9;
  localparam logic [2:0] REG_CTRL    = 3'h0;
  localparam logic [2:0] REG_MAXPL   = 3'h1;
  localparam logic [2:0] REG_STATUS  = 3'h2;
  localparam logic [2:0] REG_COUNT   = 3'h3;
  localparam logic       CTRL_EN_RST = 1'b1;
  localparam logic [7:0] MAXPL_RST   = 8'h64;
  localparam logic [2:0] HSIZE_WORD  = 3'h2;
  typedef enum logic [5:0] {
    S_HDR     = 6'h01,
    S_EXEC    = 6'h02,
    S_READ    = 6'h04,
    S_CHECK   = 6'h08,
    S_SEND    = 6'h10,
    S_INSTALL = 6'h20
  } fbrv_state_t;
endpackage
`default_nettype wire

/* File: logic/fbrv_top.sv */
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module fbrv_top #(
  parameter int NUM_BLOCKS  = 32,
  parameter int BLOCK_BYTES = 2048,
  parameter int MAX_READ    = 64
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Request byte stream
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_data,
  input  wire logic        req_last,
  input  wire logic [7:0]  req_src_ep,
  output logic             req_ready,
  // Reply byte stream
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             rsp_last,
  output logic [7:0]       rsp_dst_ep,
  input  wire logic        rsp_ready,
  // Flash byte read port
  output logic             fl_req,
  output logic [15:0]      fl_block,
  output logic [15:0]      fl_offset,
  input  wire logic        fl_ack,
  input  wire logic [7:0]  fl_rdata,
  input  wire logic        fl_err,
  input  wire logic        mem_busy,
  // Image checker and install
  output logic             chk_start,
  input  wire logic        chk_done,
  input  wire logic [7:0]  chk_status,
  output logic             rx_blocked,
  output logic             install_reset
);

  typedef struct packed {
    fbrv_pkg::fbrv_state_t         st;
    logic [7:0][7:0]               hdr;
    logic [3:0]                    hcnt;
    logic [7:0]                    status;
    logic [15:0]                   idx;
    logic [15:0]                   rcnt;
    logic [MAX_READ-1:0][7:0]      buff;
    logic                          req_ready;
    logic                          rsp_valid;
    logic [7:0]                    rsp_data;
    logic                          rsp_last;
    logic [7:0]                    rsp_ep;
    logic                          fl_req;
    logic [15:0]                   fl_offset;
    logic                          chk_start;
    logic                          rx_blocked;
    logic                          install_reset;
    logic                          hreadyout;
    logic [31:0]                   hrdata;
    logic                          a_sel;
    logic                          a_wr;
    logic [2:0]                    a_reg;
    logic                          enable;
    logic [7:0]                    maxpl;
    logic [7:0]                    last_status;
    logic [7:0]                    last_cmd;
    logic [15:0]                   done_cnt;
  } fbrv_regs_t;

  fbrv_regs_t r;
  fbrv_regs_t next_r;

  function automatic logic [15:0] word16(input logic [7:0] hi,
                                         input logic [7:0] lo);
    word16 = {hi, lo};
  endfunction

  // Reply bytes in the same order as the request header
  function automatic logic [7:0] reply_byte(input fbrv_regs_t s,
                                            input logic [15:0] i);
    logic [15:0] d;
    d = i - 16'h0008;
    case (i)
      16'h0000: reply_byte = s.hdr[0] | fbrv_pkg::REPLY_BIT; // RULE_07
      16'h0001: reply_byte = s.status; // RULE_09
      16'h0002: reply_byte = s.hdr[2]; // RULE_10
      16'h0003: reply_byte = s.hdr[3];
      16'h0004: reply_byte = s.hdr[4];
      16'h0005: reply_byte = s.hdr[5];
      16'h0006: reply_byte = s.rcnt[15:8]; // RULE_11
      16'h0007: reply_byte = s.rcnt[7:0];
      default:  reply_byte = s.buff[d[$clog2(MAX_READ)-1:0]];
    endcase
  endfunction

  logic [15:0] blk;
  logic [15:0] start;
  logic [15:0] cnt;
  logic [16:0] span;
  logic [7:0]  room;
  logic        is_chk;
  logic [15:0] nidx;
  logic        take_req;
  logic        rsp_go;
  logic        bus_go;

  always_comb
  begin
    next_r = r;
    blk = word16(r.hdr[2], r.hdr[3]); // RULE_03
    start = word16(r.hdr[4], r.hdr[5]);
    cnt = word16(r.hdr[6], r.hdr[7]);
    span = {1'b0, start} + {1'b0, cnt};
    room = r.maxpl - {4'h0, fbrv_pkg::HDR_LEN};
    is_chk = (r.hdr[0] == fbrv_pkg::CMD_CHECK) ||
             (r.hdr[0] == fbrv_pkg::CMD_INSTALL); // RULE_12
    nidx = r.idx + 16'h0001;
    take_req = req_valid && r.req_ready;
    rsp_go = r.rsp_valid && rsp_ready;
    // Narrow or out-of-range accesses are dropped, so no register aliases
    bus_go = hsel && hready && htrans[1] &&
             hsize == fbrv_pkg::HSIZE_WORD && haddr[31:5] == 27'h0;
    next_r.chk_start = 1'b0;
    next_r.install_reset = 1'b0;

    case (r.st)
      fbrv_pkg::S_HDR:
      begin
        if (take_req)
        begin
          if (r.hcnt == 4'h0)
          begin
            next_r.hdr = '0;
            next_r.rsp_ep = req_src_ep; // RULE_08
          end
          if (r.hcnt < fbrv_pkg::HDR_LEN)
            next_r.hdr[r.hcnt[2:0]] = req_data;
          if (r.hcnt != fbrv_pkg::HDR_OVER)
            next_r.hcnt = r.hcnt + 4'h1;
          if (req_last)
          begin
            // Stop taking bytes until this command is answered
            next_r.req_ready = 1'b0; // RULE_22
            next_r.st = fbrv_pkg::S_EXEC;
          end
        end
        if (!r.enable)
          next_r.req_ready = 1'b0;
        else if (!(take_req && req_last))
          next_r.req_ready = 1'b1;
      end
      fbrv_pkg::S_EXEC:
      begin
        next_r.status = fbrv_pkg::ST_OK;
        next_r.rcnt = 16'h0000;
        next_r.idx = 16'h0000;
        next_r.st = fbrv_pkg::S_SEND;
        next_r.last_cmd = r.hdr[0];
        if (mem_busy)
          next_r.status = fbrv_pkg::ST_BUSY; // RULE_20
        else if (r.hdr[0] == fbrv_pkg::CMD_FETCH)
        begin
          // A fetch carrying data bytes or a cut header is malformed
          if (r.hcnt != fbrv_pkg::HDR_LEN) // RULE_06
            next_r.status = fbrv_pkg::ST_BAD_LEN;
          else if (blk >= 16'(NUM_BLOCKS))
            next_r.status = fbrv_pkg::ST_NO_BLOCK; // RULE_18
          else if (span > 17'(BLOCK_BYTES))
            next_r.status = fbrv_pkg::ST_BOUNDARY; // RULE_04
          else if (cnt > {8'h00, room} || cnt > 16'(MAX_READ))
            next_r.status = fbrv_pkg::ST_TOO_LONG; // RULE_05 RULE_19
          else if (cnt != 16'h0000)
          begin
            next_r.st = fbrv_pkg::S_READ;
            next_r.fl_req = 1'b1;
            next_r.fl_offset = start;
          end
        end
        else if (is_chk)
        begin
          // Unused fields answer as zero
          next_r.hdr[5:2] = '0; // RULE_15
          next_r.chk_start = 1'b1; // RULE_13
          next_r.rx_blocked = 1'b1; // RULE_16
          next_r.st = fbrv_pkg::S_CHECK;
        end
        else
          next_r.status = fbrv_pkg::ST_UNKNOWN; // RULE_20
        if (next_r.st == fbrv_pkg::S_SEND)
        begin
          next_r.rsp_valid = 1'b1;
          next_r.rsp_data = reply_byte(next_r, 16'h0000);
          next_r.rsp_last = 1'b0;
        end
      end
      fbrv_pkg::S_READ:
      begin
        if (fl_ack)
        begin
          next_r.buff[r.idx[$clog2(MAX_READ)-1:0]] = fl_rdata; // RULE_11
          next_r.idx = nidx;
          next_r.fl_offset = r.fl_offset + 16'h0001;
          if (fl_err || nidx == cnt)
          begin
            next_r.fl_req = 1'b0;
            next_r.idx = 16'h0000;
            next_r.status = fl_err ? fbrv_pkg::ST_RD_FAIL : fbrv_pkg::ST_OK;
            next_r.rcnt = fl_err ? 16'h0000 : cnt; // RULE_19
            next_r.st = fbrv_pkg::S_SEND;
            next_r.rsp_valid = 1'b1;
            next_r.rsp_data = reply_byte(next_r, 16'h0000);
          end
        end
      end
      fbrv_pkg::S_CHECK:
      begin
        // Checker codes pass straight to the reply
        if (chk_done)
        begin
          next_r.status = chk_status; // RULE_21
          next_r.rx_blocked = 1'b0;
          next_r.st = fbrv_pkg::S_SEND;
          next_r.rsp_valid = 1'b1;
          next_r.rsp_data = reply_byte(next_r, 16'h0000); // RULE_17
        end
      end
      fbrv_pkg::S_SEND:
      begin
        if (rsp_go)
        begin
          if (r.rsp_last)
          begin
            next_r.rsp_valid = 1'b0;
            next_r.rsp_last = 1'b0;
            next_r.hcnt = 4'h0;
            next_r.last_status = r.status;
            next_r.done_cnt = r.done_cnt + 16'h0001;
            next_r.st = fbrv_pkg::S_HDR;
            if (r.hdr[0] == fbrv_pkg::CMD_INSTALL &&
                r.status == fbrv_pkg::ST_OK)
              next_r.st = fbrv_pkg::S_INSTALL; // RULE_14
          end
          else
          begin
            next_r.idx = nidx;
            next_r.rsp_data = reply_byte(r, nidx);
            next_r.rsp_last = (nidx == r.rcnt + 16'h0007);
          end
        end
      end
      fbrv_pkg::S_INSTALL:
      begin
        // Reset fires only after the last reply byte has left
        next_r.install_reset = 1'b1; // RULE_14
        next_r.st = fbrv_pkg::S_HDR;
      end
      default:
        next_r.st = fbrv_pkg::S_HDR;
    endcase

    // Bus data phase: write uses the address captured one cycle earlier
    if (r.a_sel && r.a_wr)
    begin
      case (r.a_reg)
        fbrv_pkg::REG_CTRL:  next_r.enable = hwdata[0];
        fbrv_pkg::REG_MAXPL: next_r.maxpl = hwdata[7:0];
        default:             next_r.done_cnt = next_r.done_cnt;
      endcase
    end
    next_r.a_sel = bus_go;
    next_r.a_wr = hwrite;
    next_r.a_reg = haddr[4:2];
    next_r.hrdata = 32'h0000_0000;
    if (bus_go && !hwrite)
    begin
      case (haddr[4:2])
        fbrv_pkg::REG_CTRL:   next_r.hrdata = {31'h0, r.enable};
        fbrv_pkg::REG_MAXPL:  next_r.hrdata = {24'h0, r.maxpl};
        fbrv_pkg::REG_STATUS:
          next_r.hrdata = {14'h0, r.rx_blocked,
                           r.st != fbrv_pkg::S_HDR,
                           r.last_cmd, r.last_status};
        fbrv_pkg::REG_COUNT:  next_r.hrdata = {16'h0, r.done_cnt};
        default:              next_r.hrdata = 32'h0000_0000;
      endcase
    end
    if (!bus_go)
      next_r.a_wr = 1'b0;
    next_r.hreadyout = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r <= '0;
      r.st <= fbrv_pkg::S_HDR;
      r.hreadyout <= 1'b1;
      r.enable <= fbrv_pkg::CTRL_EN_RST;
      r.maxpl <= fbrv_pkg::MAXPL_RST;
    end
    else
      r <= next_r;
  end

  assign hreadyout = r.hreadyout;
  assign hrdata = r.hrdata;
  assign hresp = 1'b0;
  assign req_ready = r.req_ready;
  assign rsp_valid = r.rsp_valid;
  assign rsp_data = r.rsp_data;
  assign rsp_last = r.rsp_last;
  assign rsp_dst_ep = r.rsp_ep;
  assign fl_req = r.fl_req;
  assign fl_block = {r.hdr[2], r.hdr[3]};
  assign fl_offset = r.fl_offset;
  assign chk_start = r.chk_start;
  assign rx_blocked = r.rx_blocked;
  assign install_reset = r.install_reset;

endmodule
`default_nettype wire
